// ==== design/lcdrp_pkg.sv ====
// Constants and types of the LCD reset and power-down sequencer
// Behaviour
// - Power-down pin high enters power-down; low keeps normal operation.
// - Power-down stops the internal oscillator and bias generation.
// - Power-down ties all LCD row and column outputs to ground.
// - Power-down entry and exit keep memory and all internal state unchanged.
// - Instructions run in power-down only with an external oscillator-pin clock.
// - Initialization starts by itself at power-up with no host command.
// - Initialization begins with a display-memory clear lasting 165 oscillator cycles.
// - Defaults: increment, no shift, 8-bit bus, one line, basic page, 1:18.
// - Defaults: display off, cursor off, cursor blink off.
// - After reset the address pointer selects display data memory.
// - Busy flag stays one from power-on until initialization completes.
// - Power-on busy period lasts 2 ms; host waits that long.
// - Defaults: icons, icon blink and direct drive mode disabled.
// - Defaults: the three screen configuration bits cleared.
// - Defaults: temperature coefficient zero, supply generator off, multiplier factor four.
// - While busy, only the status read is served; other instructions ignored.
package lcdrp_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BUSY_TIME_US = 2000;
  localparam int unsigned BUSY_CYCLES = (CLK_HZ / 1_000_000) * BUSY_TIME_US;
  localparam int unsigned CLEAR_OSC_CYCLES = 165;
  localparam int unsigned OSC_DIV_DEFAULT = 4;
  localparam int unsigned MEM_DEPTH = 80;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_POINTER = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0C;

  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_PD_BIT = 1;
  localparam int unsigned ST_EXEC_BIT = 2;
  localparam int unsigned ST_AC_LSB = 8;
  localparam int unsigned ST_CGRAM_BIT = 15;
  localparam int unsigned PTR_CGRAM_BIT = 7;

  typedef struct packed {
    logic increment;
    logic display_shift;
    logic display_on;
    logic cursor_on;
    logic cursor_blink;
    logic bus_width_select;
    logic two_line;
    logic ext_page;
    logic single_line_mux_select;
    logic icon_enable;
    logic icon_blink_enable;
    logic direct_drive_enable;
    logic [2:0] screen_cfg;
    logic temp_coeff_bit1;
    logic temp_coeff_bit2;
    logic [5:0] supply_level_a;
    logic [5:0] supply_level_b;
    logic multiplier_stage_hi;
    logic multiplier_stage_lo;
  } lcdrp_cfg_t;

  localparam lcdrp_cfg_t CFG_RESET = '{increment: 1'b1, bus_width_select: 1'b1,
    multiplier_stage_hi: 1'b1, default: '0};

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcdrp_bus_req_t;

  typedef enum logic [1:0] {
    INIT_CLEAR,
    INIT_SETTLE,
    INIT_READY
  } lcdrp_init_t;
endpackage

// ==== design/lcdrp_ctrl.sv ====
// LCD power-on reset sequencer and power-down control
`timescale 1ns/1ps
module lcdrp_ctrl #(
  parameter int unsigned BUSY_CYCLES_P = lcdrp_pkg::BUSY_CYCLES,
  parameter int unsigned OSC_DIV_P = lcdrp_pkg::OSC_DIV_DEFAULT
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic power_down_pin_i,
  input wire logic oscillator_pin_i,
  input wire logic ext_clock_sel_i,
  input wire lcdrp_pkg::lcdrp_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  output logic busy_flag_o,
  output logic osc_enable_o,
  output logic bias_enable_o,
  output logic lcd_ground_o,
  output logic lcd_supply_generator_on_o,
  output logic i2c_reset_o,
  output lcdrp_pkg::lcdrp_cfg_t cfg_o
);
  localparam int unsigned MEM_AW = 7;

  // Wrapping step of the address counter
  function automatic logic [MEM_AW-1:0] ac_step(input logic [MEM_AW-1:0] ac, input logic inc);
    return inc ? MEM_AW'(ac + 7'h01) : MEM_AW'(ac - 7'h01);
  endfunction

  // A pin change counts once the second and third stages agree
  function automatic logic pin_filter(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] pd_s_q;
  logic [2:0] osc_s_q;
  logic [2:0] sel_s_q;
  logic pd_q;
  logic osc_lvl_q;
  logic ext_sel_q;
  logic osc_lvl_d;
  logic ext_tick;
  logic int_run;
  logic int_tick;
  logic osc_tick;
  logic exec_ok;
  logic [15:0] div_q;
  lcdrp_pkg::lcdrp_init_t state_q;
  lcdrp_pkg::lcdrp_init_t state_d;
  logic [7:0] clr_cnt_q;
  logic [31:0] busy_cnt_q;
  logic busy_done;
  logic clear_last;
  logic clear_wr;
  logic busy;
  lcdrp_pkg::lcdrp_cfg_t cfg_q;
  logic [MEM_AW-1:0] ac_q;
  logic cgram_q;
  logic [7:0] mem_q [lcdrp_pkg::MEM_DEPTH];
  logic accept_wr;
  logic accept_rd;
  logic wr_cfg;
  logic wr_ptr;
  logic wr_data;
  logic ac_in_range;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;

  // Reset released through two flops; power-up alone starts the sequence
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_s_q <= 3'h0;
      osc_s_q <= 3'h0;
      sel_s_q <= 3'h0;
    end else begin
      pd_s_q <= {pd_s_q[1:0], power_down_pin_i};
      osc_s_q <= {osc_s_q[1:0], oscillator_pin_i};
      sel_s_q <= {sel_s_q[1:0], ext_clock_sel_i};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
      osc_lvl_q <= 1'b0;
      ext_sel_q <= 1'b0;
    end else begin
      pd_q <= pin_filter(pd_s_q, pd_q);
      osc_lvl_q <= osc_lvl_d;
      ext_sel_q <= pin_filter(sel_s_q, ext_sel_q);
    end
  end

  assign osc_lvl_d = pin_filter(osc_s_q, osc_lvl_q);
  assign ext_tick = osc_lvl_d & ~osc_lvl_q;
  assign int_run = !pd_q && !ext_sel_q;
  assign int_tick = int_run && (div_q == 16'(OSC_DIV_P - 1));
  assign osc_tick = ext_sel_q ? ext_tick : int_tick;
  // execution needs a clock in power-down
  assign exec_ok = !pd_q || ext_sel_q;

  // Divider holds its phase while stopped, so resume is seamless
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
    end else if (int_run) begin
      div_q <= int_tick ? 16'h0000 : 16'(div_q + 16'h0001);
    end
  end

  // clear step length in oscillator cycles
  assign clear_last = osc_tick && (clr_cnt_q == 8'(lcdrp_pkg::CLEAR_OSC_CYCLES - 1));
  assign clear_wr = (state_q == lcdrp_pkg::INIT_CLEAR) && osc_tick
    && (clr_cnt_q < 8'(lcdrp_pkg::MEM_DEPTH));
  // busy period counted in system clocks
  assign busy_done = busy_cnt_q >= BUSY_CYCLES_P;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lcdrp_pkg::INIT_CLEAR: begin
        if (clear_last) begin
          state_d = lcdrp_pkg::INIT_SETTLE;
        end
      end
      lcdrp_pkg::INIT_SETTLE: begin
        if (busy_done) begin
          state_d = lcdrp_pkg::INIT_READY;
        end
      end
      lcdrp_pkg::INIT_READY: begin
        state_d = lcdrp_pkg::INIT_READY;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= lcdrp_pkg::INIT_CLEAR;
      clr_cnt_q <= 8'h00;
      busy_cnt_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (state_q == lcdrp_pkg::INIT_CLEAR && osc_tick) begin
        clr_cnt_q <= 8'(clr_cnt_q + 8'h01);
      end
      // Frozen while no clock runs, so the 2 ms is never shortened
      if (exec_ok && !busy_done) begin
        busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign busy = state_q != lcdrp_pkg::INIT_READY;

  assign accept_wr = bus_i.wr && !busy && exec_ok;
  assign accept_rd = bus_i.rd && !busy && exec_ok;
  assign wr_cfg = accept_wr && (bus_i.addr == lcdrp_pkg::ADDR_CONFIG);
  assign wr_ptr = accept_wr && (bus_i.addr == lcdrp_pkg::ADDR_POINTER);
  assign wr_data = accept_wr && (bus_i.addr == lcdrp_pkg::ADDR_DATA);
  assign ac_in_range = 32'(ac_q) < lcdrp_pkg::MEM_DEPTH;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= lcdrp_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= bus_i.wdata[$bits(lcdrp_pkg::lcdrp_cfg_t)-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ac_q <= 7'h00;
      cgram_q <= 1'b0;
    end else if (wr_ptr) begin
      ac_q <= bus_i.wdata[MEM_AW-1:0];
      cgram_q <= bus_i.wdata[lcdrp_pkg::PTR_CGRAM_BIT];
    end else if (wr_data) begin
      ac_q <= ac_step(ac_q, cfg_q.increment);
    end
  end

  // memory cleared one cell per oscillator cycle
  // Not reset: contents are defined by the clear and survive power-down
  always_ff @(posedge clock_i) begin
    if (clear_wr) begin
      mem_q[clr_cnt_q[MEM_AW-1:0]] <= 8'h00;
    end else if (wr_data && !cgram_q && ac_in_range) begin
      mem_q[ac_q] <= bus_i.wdata[7:0];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lcdrp_pkg::ST_BUSY_BIT] = busy;
    status_word[lcdrp_pkg::ST_PD_BIT] = pd_q;
    status_word[lcdrp_pkg::ST_EXEC_BIT] = exec_ok;
    status_word[lcdrp_pkg::ST_AC_LSB +: MEM_AW] = ac_q;
    status_word[lcdrp_pkg::ST_CGRAM_BIT] = cgram_q;
  end

  assign rd_mux = (bus_i.addr == lcdrp_pkg::ADDR_STATUS) ? status_word
    : !accept_rd ? 32'h0000_0000
    : (bus_i.addr == lcdrp_pkg::ADDR_CONFIG) ? 32'(cfg_q)
    : (bus_i.addr == lcdrp_pkg::ADDR_POINTER) ? {24'h000000, cgram_q, ac_q}
    : (bus_i.addr == lcdrp_pkg::ADDR_DATA && !cgram_q && ac_in_range) ? {24'h000000, mem_q[ac_q]}
    : 32'h0000_0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= bus_i.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;
  assign busy_flag_o = busy;
  assign cfg_o = cfg_q;
  assign osc_enable_o = int_run;
  assign bias_enable_o = !pd_q;
  assign lcd_ground_o = pd_q;
  // generator off while both levels zero
  assign lcd_supply_generator_on_o = !pd_q && ((cfg_q.supply_level_a != 6'h00)
    || (cfg_q.supply_level_b != 6'h00));
  assign i2c_reset_o = state_q == lcdrp_pkg::INIT_CLEAR;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_pd_stable;
    pd_s_q[1] && pd_s_q[2];
  endsequence

  sequence s_write_blocked;
    bus_i.wr && (busy || !exec_ok);
  endsequence

  sequence s_reset_left;
    $rose(rst_n);
  endsequence

  sequence s_read_refused;
    bus_i.rd && !accept_rd && (bus_i.addr != lcdrp_pkg::ADDR_STATUS);
  endsequence

  sequence s_clear_done;
    state_q == lcdrp_pkg::INIT_SETTLE && $past(state_q) == lcdrp_pkg::INIT_CLEAR;
  endsequence

  sequence s_ext_cfg_write;
    pd_q && ext_sel_q && !busy && bus_i.wr && (bus_i.addr == lcdrp_pkg::ADDR_CONFIG);
  endsequence

  a_pd_entry_seen: assert property (s_pd_stable |=> pd_q)
    else $error("power-down not entered after stable pin high");
  a_pd_exit_seen: assert property (!pd_s_q[1] && !pd_s_q[2] |=> !pd_q)
    else $error("power-down not left after stable pin low");
  // Divider still steps in the cycle of entry, so it is judged a cycle later
  a_pd_osc_stop: assert property (pd_q |-> (!osc_enable_o && !bias_enable_o) ##1 $stable(div_q))
    else $error("oscillator or bias active in power-down");
  a_pd_lcd_ground: assert property (lcd_ground_o == pd_q)
    else $error("LCD outputs not grounded in power-down");
  // A host write in that cycle is its own change, not the power-down's
  a_pd_state_kept: assert property ($changed(pd_q) && !accept_wr |=> $stable(cfg_q) && $stable(ac_q))
    else $error("state changed by power-down edge");
  a_pd_no_exec: assert property (pd_q && !ext_sel_q |-> !accept_wr && !osc_tick)
    else $error("instruction executed in power-down without clock");
  a_clear_cell: assert property (clear_wr ##1 1'b1 |-> mem_q[$past(clr_cnt_q[MEM_AW-1:0])] == 8'h00)
    else $error("display memory cell not cleared");
  a_clear_length: assert property (s_clear_done |-> $past(clr_cnt_q) == 8'(lcdrp_pkg::CLEAR_OSC_CYCLES - 1))
    else $error("clear step left at wrong oscillator count");
  a_init_defaults: assert property (busy |-> cfg_q == lcdrp_pkg::CFG_RESET && !cgram_q)
    else $error("defaults disturbed during initialization");
  a_busy_hold: assert property (busy && !busy_done |=> busy_flag_o)
    else $error("busy flag dropped before 2 ms");
  a_busy_release: assert property (busy_done && state_q == lcdrp_pkg::INIT_SETTLE |=> !busy_flag_o [*2])
    else $error("busy flag not released after initialization");
  a_busy_ignore: assert property (s_write_blocked |=> $stable(cfg_q) && $stable(ac_q))
    else $error("write executed while busy");
  a_i2c_idle: assert property ($fell(busy_flag_o) |-> $past(!i2c_reset_o))
    else $error("I2C reset still active at ready");

  a_rst_seq_start: assert property (s_reset_left
    |-> busy_flag_o && i2c_reset_o && state_q == lcdrp_pkg::INIT_CLEAR)
    else $error("initialization not started at reset release");

  a_rst_entry_mode: assert property (s_reset_left
    |-> cfg_q.increment && !cfg_q.display_shift && cfg_q.bus_width_select && !cfg_q.two_line
    && !cfg_q.ext_page && !cfg_q.single_line_mux_select)
    else $error("entry mode or function defaults wrong after reset");

  a_rst_display_off: assert property (s_reset_left
    |-> !cfg_q.display_on && !cfg_q.cursor_on && !cfg_q.cursor_blink)
    else $error("display not off after reset");

  a_rst_pointer_display_data_memory: assert property (s_reset_left |-> !cgram_q)
    else $error("pointer not on display memory after reset");

  a_rst_icons_off: assert property (s_reset_left
    |-> !cfg_q.icon_enable && !cfg_q.icon_blink_enable && !cfg_q.direct_drive_enable)
    else $error("icon defaults wrong after reset");

  a_rst_screen_cfg: assert property (s_reset_left |-> cfg_q.screen_cfg == 3'h0)
    else $error("screen configuration not cleared after reset");

  a_rst_supply_off: assert property (s_reset_left
    |-> !cfg_q.temp_coeff_bit1 && !cfg_q.temp_coeff_bit2 && cfg_q.supply_level_a == 6'h00
    && cfg_q.supply_level_b == 6'h00 && cfg_q.multiplier_stage_hi && !cfg_q.multiplier_stage_lo
    && !lcd_supply_generator_on_o)
    else $error("supply defaults wrong after reset");

  a_clear_ticks: assert property (state_q == lcdrp_pkg::INIT_CLEAR && !osc_tick |=> $stable(clr_cnt_q))
    else $error("clear advanced without oscillator tick");

  a_ext_exec: assert property (s_ext_cfg_write
    |=> cfg_q == $past(bus_i.wdata[$bits(lcdrp_pkg::lcdrp_cfg_t)-1:0]))
    else $error("write not executed in power-down with external clock");

  a_busy_frozen: assert property (pd_q && !ext_sel_q |=> $stable(busy_cnt_q))
    else $error("busy period counted without a clock");

  a_read_refused: assert property (s_read_refused |=> rdata_o == 32'h0000_0000)
    else $error("refused read returned data");

  a_status_served: assert property (bus_i.rd && bus_i.addr == lcdrp_pkg::ADDR_STATUS
    |=> rdata_o[lcdrp_pkg::ST_BUSY_BIT] == $past(busy))
    else $error("status read did not return busy flag");
endmodule

// ==== tb/lcdrp_host.sv ====
// Host microcontroller model on the register port
`timescale 1ns/1ps
module lcdrp_host (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  output lcdrp_pkg::lcdrp_bus_req_t bus_o
);
  initial bus_o = '{addr: 8'hFF, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    // Idle lines flip so a stale copy never looks valid
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_o <= '{addr: ~a, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask
  // Poll busy before treating device as ready
  task automatic wait_ready();
    logic [31:0] s;
    int k;
    s = 32'h1;
    k = 0;
    while (s[lcdrp_pkg::ST_BUSY_BIT] !== 1'b0 && k < 1000) begin
      read_reg(lcdrp_pkg::ADDR_STATUS, s);
      k++;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the LCD reset and power-down sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic power_down_pin_i = 1'b0;
  logic oscillator_pin_i = 1'b0;
  logic ext_clock_sel_i = 1'b0;
  lcdrp_pkg::lcdrp_bus_req_t bus_i;
  logic [31:0] rdata_o;
  logic busy_flag_o;
  logic osc_enable_o;
  logic bias_enable_o;
  logic lcd_ground_o;
  logic lcd_supply_generator_on_o;
  logic i2c_reset_o;
  lcdrp_pkg::lcdrp_cfg_t cfg_o;
  lcdrp_pkg::lcdrp_cfg_t c;
  lcdrp_pkg::lcdrp_cfg_t c2;
  logic [31:0] d;
  logic [1:0] osc_div = 2'h0;
  // Rows: pd, ext, osc_en, bias_en, ground, exec
  logic [5:0] rows [4] = '{6'b00_1101, 6'b10_0010, 6'b01_0101, 6'b11_0011};
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int t0;
  int el;

  lcdrp_ctrl #(.BUSY_CYCLES_P(300), .OSC_DIV_P(1)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .power_down_pin_i(power_down_pin_i),
    .oscillator_pin_i(oscillator_pin_i), .ext_clock_sel_i(ext_clock_sel_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .busy_flag_o(busy_flag_o), .osc_enable_o(osc_enable_o),
    .bias_enable_o(bias_enable_o), .lcd_ground_o(lcd_ground_o),
    .lcd_supply_generator_on_o(lcd_supply_generator_on_o), .i2c_reset_o(i2c_reset_o), .cfg_o(cfg_o)
  );
  lcdrp_host host_u (.clock_i(clock_i), .rdata_i(rdata_o), .bus_o(bus_i));

  initial begin
    forever #4 clock_i = ~clock_i;
  end
  // External oscillator at clock/8, only while selected
  always @(posedge clock_i) begin
    osc_div <= osc_div + 2'h1;
    if (ext_clock_sel_i && osc_div == 2'h3) oscillator_pin_i <= ~oscillator_pin_i;
  end
  // Run is under 800 cycles; ceiling leaves wide margin
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic reset_check();
    `CHK(cfg_o, lcdrp_pkg::CFG_RESET)
    `CHK(busy_flag_o, 1'b1)
    `CHK(i2c_reset_o, 1'b1)
    `CHK(lcd_supply_generator_on_o, 1'b0)
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    reset_check();
    rstn_i <= 1'b1;
    t0 = cycles;
    repeat (4) @(posedge clock_i);
    host_u.read_reg(lcdrp_pkg::ADDR_STATUS, d);
    `CHK(d[lcdrp_pkg::ST_BUSY_BIT], 1'b1)
    c = lcdrp_pkg::CFG_RESET;
    c.display_on = 1'b1;
    c.supply_level_a = 6'h01;
    host_u.write_reg(lcdrp_pkg::ADDR_CONFIG, {1'b0, c});
    #1 `CHK(cfg_o, lcdrp_pkg::CFG_RESET)
    host_u.read_reg(lcdrp_pkg::ADDR_CONFIG, d);
    `CHK(d, 32'h0000_0000)
    // Release adds three edges; with OSC_DIV_P of 1 the internal oscillator ticks every clock
    while (i2c_reset_o === 1'b1 && cycles < t0 + 1000) @(posedge clock_i);
    el = cycles - t0;
    `CHK(el, lcdrp_pkg::CLEAR_OSC_CYCLES + 3)
    while (busy_flag_o === 1'b1 && cycles < t0 + 1000) @(posedge clock_i);
    el = cycles - t0;
    `CHK(el >= 300 && el <= 306, 1'b1)
    `CHK(i2c_reset_o, 1'b0)
    host_u.read_reg(lcdrp_pkg::ADDR_STATUS, d);
    `CHK(d[lcdrp_pkg::ST_CGRAM_BIT], 1'b0)
    host_u.read_reg(lcdrp_pkg::ADDR_POINTER, d);
    `CHK(d[lcdrp_pkg::PTR_CGRAM_BIT], 1'b0)
    host_u.write_reg(lcdrp_pkg::ADDR_CONFIG, {1'b0, c});
    #1 `CHK(cfg_o, c)
    `CHK(lcd_supply_generator_on_o, 1'b1)
    host_u.write_reg(lcdrp_pkg::ADDR_POINTER, 32'h0000_0005);
    host_u.write_reg(lcdrp_pkg::ADDR_DATA, 32'h0000_00A5);
    host_u.read_reg(8'h10, d);
    `CHK(d, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      power_down_pin_i <= rows[i][5];
      ext_clock_sel_i <= rows[i][4];
      repeat (8) @(posedge clock_i);
      #1 `CHK(osc_enable_o, rows[i][3])
      `CHK(bias_enable_o, rows[i][2])
      `CHK(lcd_ground_o, rows[i][1])
      `CHK(lcd_supply_generator_on_o, ~rows[i][5])
      host_u.read_reg(lcdrp_pkg::ADDR_STATUS, d);
      `CHK(d[lcdrp_pkg::ST_PD_BIT], rows[i][5])
      `CHK(d[lcdrp_pkg::ST_EXEC_BIT], rows[i][0])
    end
    c2 = c;
    c2.cursor_on = 1'b1;
    @(posedge clock_i);
    ext_clock_sel_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    host_u.write_reg(lcdrp_pkg::ADDR_CONFIG, {1'b0, c2});
    #1 `CHK(cfg_o, c)
    @(posedge clock_i);
    ext_clock_sel_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    host_u.write_reg(lcdrp_pkg::ADDR_CONFIG, {1'b0, c2});
    #1 `CHK(cfg_o, c2)
    @(posedge clock_i);
    power_down_pin_i <= 1'b0;
    ext_clock_sel_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    host_u.write_reg(lcdrp_pkg::ADDR_POINTER, 32'h0000_0005);
    host_u.read_reg(lcdrp_pkg::ADDR_DATA, d);
    `CHK(d[7:0], 8'hA5)
    `CHK(cfg_o, c2)
    @(posedge clock_i);
    rstn_i <= 1'b0;
    @(posedge clock_i);
    #1 reset_check();
    @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    host_u.wait_ready();
    `CHK(busy_flag_o, 1'b0)
    host_u.write_reg(lcdrp_pkg::ADDR_POINTER, 32'h0000_0005);
    host_u.read_reg(lcdrp_pkg::ADDR_DATA, d);
    `CHK(d[7:0], 8'h00)
    tally_and_finish();
  end
endmodule
